/* core/zone_flag_pkg.sv */
package zone_flag_pkg;

  // ----------------------------------------------------------------
  // address space of the serial bit array
  // ----------------------------------------------------------------
  localparam int ADDR_W = 11;
  typedef logic [ADDR_W-1:0] bit_addr_t;

  // bits whose stored one opens a read window, zones 1..3
  localparam bit_addr_t RD_BIT [3] = '{11'h0b1, 11'h1e1, 11'h401};
  // application zone ranges, zones 1..3
  localparam bit_addr_t ZONE_LO [3] = '{11'h0b0, 11'h1e0, 11'h400};
  localparam bit_addr_t ZONE_HI [3] = '{11'h1af, 11'h2df, 11'h5ff};
  // bit on which an erase triggers the whole-zone erase, zones 1..3
  localparam bit_addr_t ZONE_TRIG [3] = '{11'h1e0, 11'h300, 11'h630};
  // word of the trigger bit is left alone, zone 1, and zone 2 with the fuse at zero
  localparam logic [2:0] ZONE_KEEP_WORD = 3'h3;

  // passwords: 0 security code, 1..3 zone erase codes
  localparam bit_addr_t PW_LO [4] = '{11'h050, 11'h1b0, 11'h2e0, 11'h600};
  localparam bit_addr_t PW_HI [4] = '{11'h05f, 11'h1df, 11'h2ff, 11'h62f};

  // attempt counter and zone 2 erase counter windows
  localparam bit_addr_t SCAC_LO = 11'h060;
  localparam bit_addr_t SCAC_HI = 11'h063;
  localparam bit_addr_t ZONE2_CNT_LO = 11'h300;
  localparam bit_addr_t ZONE2_CNT_HI = 11'h37f;
  localparam bit_addr_t ADDR_ZERO = 11'h000;

  // zone 2 erase allowance while the limit fuse is unblown
  localparam logic [7:0] ZONE2_ERASE_LIMIT = 8'h80;

  // ----------------------------------------------------------------
  // apb register map
  // ----------------------------------------------------------------
  localparam logic [11:0] CTRL_OFS = 12'h000;
  localparam logic [11:0] STATUS_OFS = 12'h004;
  localparam logic [11:0] ECOUNT_OFS = 12'h008;
  localparam int CTRL_FUSE_BIT = 0;
  localparam logic CTRL_FUSE_RST = 1'h1;
  localparam int STAT_RD_POS = 0;
  localparam int STAT_ER_POS = 3;
  localparam int STAT_SEC_POS = 6;
  localparam int STAT_SECBUSY_POS = 7;
  localparam int STAT_Z2BUSY_POS = 8;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {OP_STEP, OP_COMPARE, OP_WRITE, OP_ERASE} op_kind_t;

  typedef struct packed {
    logic valid;
    op_kind_t kind;
    bit_addr_t addr;
    logic mem_bit;
    logic io_bit;
  } card_op_t;

  typedef struct packed {
    logic req;
    bit_addr_t first;
    bit_addr_t last;
    logic keep_word;
  } zone_erase_t;

  typedef enum logic [1:0] {VAL_IDLE, VAL_ARMED, VAL_WRITTEN} val_state_t;

  typedef struct packed {
    val_state_t state;
    bit_addr_t addr;
    logic done;
    logic fail;
  } val_step_t;

endpackage : zone_flag_pkg

/* core/code_matcher.sv */
`timescale 1ns/10ps
module code_matcher
  import zone_flag_pkg::*;
#(
  parameter bit_addr_t LO = 11'h000,
  parameter bit_addr_t HI = 11'h000
)
(
  input wire logic clk,
  input wire logic srst,
  input wire card_op_t op,
  output logic matched
);

  // ----------------------------------------------------------------
  // bit-serial password comparison
  // ----------------------------------------------------------------
  logic run_ff;
  logic nxt_run;
  bit_addr_t expect_ff;
  bit_addr_t nxt_expect;
  logic matched_ff;
  logic nxt_matched;

  wire logic is_cmp = op.valid && (op.kind == OP_COMPARE);
  wire logic bit_ok = (op.io_bit == op.mem_bit);
  wire logic at_first = is_cmp && (op.addr == LO);
  wire logic at_next = is_cmp && run_ff && (op.addr == expect_ff);
  wire logic in_range = (op.addr >= LO) && (op.addr <= HI);

  // a run starts at the first bit and must hit every bit in order
  always_comb
  begin
    nxt_run = run_ff;
    nxt_expect = expect_ff;
    nxt_matched = 1'b0;
    if (at_first)
    begin
      nxt_run = bit_ok && (LO != HI);
      nxt_expect = bit_addr_t'(LO + 11'h001);
      nxt_matched = bit_ok && (LO == HI);
    end
    else if (at_next)
    begin
      nxt_run = bit_ok && (op.addr != HI);
      nxt_expect = bit_addr_t'(op.addr + 11'h001);
      nxt_matched = bit_ok && (op.addr == HI);
    end
    else if (op.valid && (in_range || op.addr == ADDR_ZERO))
    begin
      nxt_run = 1'b0; // any other touch of the code spoils the run
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      run_ff <= 1'b0;
      expect_ff <= ADDR_ZERO;
      matched_ff <= 1'b0;
    end
    else
    begin
      run_ff <= nxt_run;
      expect_ff <= nxt_expect;
      matched_ff <= nxt_matched;
    end
  end

  assign matched = matched_ff;

endmodule : code_matcher

/* core/zone_flag_ctrl.sv */
// Added by the designer: the register addresses and register access over APB.
`timescale 1ns/10ps
// Summary of operation
// - Zone 1 read flag sets when bit 177 is addressed while it holds a one.
// - Zone 2 read flag sets when bit 481 is addressed while it holds a one.
// - Zone 3 read flag sets when bit 1025 is addressed while it holds a one.
// - A read flag stays set until power-off even if its bit is later cleared.
// - Zone 1 bits are readable only while its read flag or the security flag is set.
// - Zone 2 bits are readable only while its read flag or the security flag is set.
// - Zone 3 bits are readable only while its read flag or the security flag is set.
// - Zone 1 erase flag sets on a good zone 1 erase password comparison.
// - Zone erase flags clear whenever the address counter is zero, except a flag that sets in that same cycle.
// - With zone 1 erase flag set, an erase at bit 480 wipes bits 176-431 but not its own word.
// - With the limit fuse at one, zone 2 erase flag sets after its password matches bit by bit.
// - In counter mode a one in 768-895 is written then erased, then zone 2 bits 480-735 erase.
// - With the fuse at zero, an erase at 768 under the flag wipes 480-735 but not its word.
// - Zone 3 erase flag sets on a good zone 3 erase password comparison.
// - With zone 3 erase flag set, an erase at bit 1584 wipes bits 1024-1535.
// - The security flag sets only after the code at 80-95 matches and the attempt check ends.
// - With the fuse unblown zone 2 erases stop at 128; with it blown they are unlimited.
module zone_flag_ctrl
  import zone_flag_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire card_op_t op,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [2:0] zone_read_flag,
  output logic [2:0] zone_read_en,
  output logic [2:0] zone_erase_flag,
  output logic security_valid_flag,
  output logic read_allowed,
  output logic check_valid,
  output logic check_bit,
  output zone_erase_t zone_erase
);

  // ----------------------------------------------------------------
  // shared decoding
  // ----------------------------------------------------------------

  // one step of a write-then-erase validation in a counter window
  function automatic val_step_t val_step(
    input val_state_t st,
    input bit_addr_t held,
    input card_op_t cur,
    input logic arm,
    input bit_addr_t lo,
    input bit_addr_t hi
  );
    val_step_t r;
    logic in_win;
    r.state = st;
    r.addr = held;
    r.done = 1'b0;
    r.fail = 1'b0;
    in_win = (cur.addr >= lo) && (cur.addr <= hi);
    if (arm)
    begin
      r.state = VAL_ARMED;
    end
    else if (cur.valid)
    begin
      case (st)
        VAL_ARMED:
        begin
          if (cur.kind == OP_WRITE && in_win && cur.mem_bit)
          begin
            r.state = VAL_WRITTEN;
            r.addr = cur.addr;
          end
          else if (cur.kind != OP_STEP)
          begin
            r.state = VAL_IDLE;
            r.fail = 1'b1;
          end
        end
        VAL_WRITTEN:
        begin
          if (cur.kind == OP_ERASE && cur.addr == held)
          begin
            r.state = VAL_IDLE;
            r.done = 1'b1;
          end
          else if (cur.kind != OP_STEP)
          begin
            r.state = VAL_IDLE;
            r.fail = 1'b1;
          end
        end
        default:
        begin
          r.state = VAL_IDLE;
        end
      endcase
    end
    return r;
  endfunction : val_step

  // ----------------------------------------------------------------
  // password comparators
  // ----------------------------------------------------------------
  logic [3:0] pw_match;

  // 0 security code, 1..3 zone erase codes
  for (genvar p = 0; p < 4; p++)
  begin : g_pw
    code_matcher #(
      .LO(PW_LO[p]),
      .HI(PW_HI[p])
    ) u_match (
      .clk(clk),
      .srst(srst),
      .op(op),
      .matched(pw_match[p])
    );
  end

  // ----------------------------------------------------------------
  // registers and next values
  // ----------------------------------------------------------------
  logic [2:0] rd_flag_ff;
  logic [2:0] nxt_rd_flag;
  logic [2:0] er_flag_ff;
  logic [2:0] nxt_er_flag;
  logic sec_ff;
  logic [2:0] ren_ff;
  logic fuse_ff;
  logic nxt_fuse;
  logic [7:0] ecount_ff;
  logic [7:0] nxt_ecount;
  val_state_t sec_st_ff;
  bit_addr_t sec_addr_ff;
  val_state_t z2_st_ff;
  bit_addr_t z2_addr_ff;
  logic rd_allow_ff;
  logic chk_valid_ff;
  logic chk_bit_ff;
  zone_erase_t erase_ff;
  zone_erase_t nxt_erase;
  logic [31:0] prdata_ff;
  logic pready_ff;
  logic pslverr_ff;

  // ----------------------------------------------------------------
  // read flags and read gating
  // ----------------------------------------------------------------
  logic [2:0] in_zone;

  for (genvar z = 0; z < 3; z++)
  begin : g_rd
    // flag bit addressed while holding a one; only power-off clears it
    assign nxt_rd_flag[z] = rd_flag_ff[z] ||
      (op.valid && op.addr == RD_BIT[z] && op.mem_bit);
    assign in_zone[z] = (op.addr >= ZONE_LO[z]) && (op.addr <= ZONE_HI[z]);
  end

  // zone readable while its own flag or the security flag stands
  wire logic [2:0] rd_en = rd_flag_ff | {3{sec_ff}};
  wire logic nxt_rd_allow = ((in_zone & ~rd_en) == 3'h0);

  // ----------------------------------------------------------------
  // security validation sequence
  // ----------------------------------------------------------------
  val_step_t sec_step;
  assign sec_step = val_step(sec_st_ff, sec_addr_ff, op, pw_match[0], SCAC_LO, SCAC_HI);
  wire logic nxt_sec = sec_ff || sec_step.done;

  // ----------------------------------------------------------------
  // zone 2 counter validation
  // ----------------------------------------------------------------
  wire logic z2_room = !fuse_ff || (ecount_ff < ZONE2_ERASE_LIMIT);
  wire logic z2_arm = pw_match[2] && fuse_ff && z2_room;
  val_step_t z2_step;
  assign z2_step = val_step(z2_st_ff, z2_addr_ff, op, z2_arm, ZONE2_CNT_LO, ZONE2_CNT_HI);

  // ----------------------------------------------------------------
  // erase flags
  // ----------------------------------------------------------------
  wire logic at_zero = op.valid && (op.addr == ADDR_ZERO);
  wire logic [2:0] er_set =
    {pw_match[3], pw_match[2] && z2_room, pw_match[1]};

  // set wins over the clear at address zero
  assign nxt_er_flag = er_set | (er_flag_ff & {3{!at_zero}});

  // ----------------------------------------------------------------
  // whole-zone erase triggers
  // ----------------------------------------------------------------
  wire logic is_erase = op.valid && (op.kind == OP_ERASE);
  wire logic trig_z1 = is_erase && er_flag_ff[0] && op.addr == ZONE_TRIG[0];
  wire logic trig_z2_plain = is_erase && er_flag_ff[1] && !fuse_ff &&
    op.addr == ZONE_TRIG[1];
  wire logic trig_z2_count = z2_step.done && er_flag_ff[1];
  wire logic trig_z3 = is_erase && er_flag_ff[2] && op.addr == ZONE_TRIG[2];
  wire logic trig_z2 = trig_z2_plain || trig_z2_count;

  // selected zone range, keep flag for the trigger word
  always_comb
  begin
    nxt_erase.req = trig_z1 || trig_z2 || trig_z3;
    nxt_erase.first = erase_ff.first;
    nxt_erase.last = erase_ff.last;
    nxt_erase.keep_word = erase_ff.keep_word;
    if (trig_z1)
    begin
      nxt_erase.first = ZONE_LO[0];
      nxt_erase.last = ZONE_HI[0];
      nxt_erase.keep_word = ZONE_KEEP_WORD[0];
    end
    else if (trig_z2)
    begin
      nxt_erase.first = ZONE_LO[1];
      nxt_erase.last = ZONE_HI[1];
      nxt_erase.keep_word = trig_z2_plain && ZONE_KEEP_WORD[1];
    end
    else if (trig_z3)
    begin
      nxt_erase.first = ZONE_LO[2];
      nxt_erase.last = ZONE_HI[2];
      nxt_erase.keep_word = ZONE_KEEP_WORD[2];
    end
  end

  // zone 2 erases counted while the limit fuse is unblown
  assign nxt_ecount = (trig_z2 && fuse_ff && ecount_ff < ZONE2_ERASE_LIMIT) ?
    8'(ecount_ff + 8'h01) : ecount_ff;

  // ----------------------------------------------------------------
  // apb slave decode
  // ----------------------------------------------------------------
  wire logic apb_access = psel && penable && !pready_ff;
  wire logic apb_commit = psel && penable && pready_ff;
  wire logic hit_ctrl = (paddr == CTRL_OFS);
  wire logic hit_status = (paddr == STATUS_OFS);
  wire logic hit_ecount = (paddr == ECOUNT_OFS);
  wire logic hit_any = hit_ctrl || hit_status || hit_ecount;
  logic [31:0] rd_word;

  // read mux
  always_comb
  begin
    rd_word = 32'h0000_0000;
    if (hit_ctrl)
    begin
      rd_word[CTRL_FUSE_BIT] = fuse_ff;
    end
    else if (hit_status)
    begin
      rd_word[STAT_RD_POS +: 3] = rd_flag_ff;
      rd_word[STAT_ER_POS +: 3] = er_flag_ff;
      rd_word[STAT_SEC_POS] = sec_ff;
      rd_word[STAT_SECBUSY_POS] = (sec_st_ff != VAL_IDLE);
      rd_word[STAT_Z2BUSY_POS] = (z2_st_ff != VAL_IDLE);
    end
    else if (hit_ecount)
    begin
      rd_word[7:0] = ecount_ff;
    end
  end

  // fuse written at the committing edge only
  assign nxt_fuse = (apb_commit && pwrite && hit_ctrl && pstrb[0]) ?
    pwdata[CTRL_FUSE_BIT] : fuse_ff;

  // ----------------------------------------------------------------
  // state registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      rd_flag_ff <= 3'h0;
      er_flag_ff <= 3'h0;
      sec_ff <= 1'b0;
      ren_ff <= 3'h0;
      fuse_ff <= CTRL_FUSE_RST;
      ecount_ff <= 8'h00;
    end
    else
    begin
      rd_flag_ff <= nxt_rd_flag;
      er_flag_ff <= nxt_er_flag;
      sec_ff <= nxt_sec;
      ren_ff <= nxt_rd_flag | {3{nxt_sec}};
      fuse_ff <= nxt_fuse;
      ecount_ff <= nxt_ecount;
    end
  end

  // validation sequencers
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      sec_st_ff <= VAL_IDLE;
      sec_addr_ff <= ADDR_ZERO;
      z2_st_ff <= VAL_IDLE;
      z2_addr_ff <= ADDR_ZERO;
    end
    else
    begin
      sec_st_ff <= sec_step.state;
      sec_addr_ff <= sec_step.addr;
      z2_st_ff <= z2_step.state;
      z2_addr_ff <= z2_step.addr;
    end
  end

  // per-operation results: read gate, check answer, zone erase
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      rd_allow_ff <= 1'b0;
      chk_valid_ff <= 1'b0;
      chk_bit_ff <= 1'b0;
      erase_ff <= '0;
    end
    else
    begin
      rd_allow_ff <= op.valid ? nxt_rd_allow : rd_allow_ff;
      chk_valid_ff <= sec_step.done || sec_step.fail;
      chk_bit_ff <= sec_step.done;
      erase_ff <= nxt_erase;
    end
  end

  // apb answer one cycle into the access phase
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
    end
    else
    begin
      pready_ff <= apb_access;
      pslverr_ff <= apb_access && !hit_any;
      prdata_ff <= (apb_access && !pwrite) ? rd_word : 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign zone_read_flag = rd_flag_ff;
  assign zone_read_en = ren_ff;
  assign zone_erase_flag = er_flag_ff;
  assign security_valid_flag = sec_ff;
  assign read_allowed = rd_allow_ff;
  assign check_valid = chk_valid_ff;
  assign check_bit = chk_bit_ff;
  assign zone_erase = erase_ff;

endmodule : zone_flag_ctrl

/* sim/zone_flag_ctrl_monitor.sv */
`timescale 1ns/10ps
module zone_flag_ctrl_monitor
  import zone_flag_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire card_op_t op,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic [2:0] zone_read_flag,
  input wire logic [2:0] zone_read_en,
  input wire logic [2:0] zone_erase_flag,
  input wire logic security_valid_flag,
  input wire logic check_valid,
  input wire logic check_bit,
  input wire zone_erase_t zone_erase
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  // ----------------------------------------------------------------
  // whole-zone erase request shape
  // ----------------------------------------------------------------
  property p_wipe(int z, logic keep);
    op.valid && op.kind == OP_ERASE && op.addr == ZONE_TRIG[z] && zone_erase_flag[z]
    |=> zone_erase.req && zone_erase.first == ZONE_LO[z] && zone_erase.last == ZONE_HI[z]
    && zone_erase.keep_word == keep;
  endproperty

  // ----------------------------------------------------------------
  // flag, wipe and apb checks
  // ----------------------------------------------------------------
  AST_RD1_SET:
    assert property (op.valid && op.mem_bit && op.addr == RD_BIT[0] |=> zone_read_flag[0])
      else $error("zone 1 read flag missed");
  AST_RD2_SET:
    assert property (op.valid && op.mem_bit && op.addr == RD_BIT[1] |=> zone_read_flag[1])
      else $error("zone 2 read flag missed");
  AST_RD3_SET:
    assert property (op.valid && op.mem_bit && op.addr == RD_BIT[2] |=> zone_read_flag[2])
      else $error("zone 3 read flag missed");
  AST_RD_HOLD:
    assert property (|zone_read_flag
      |=> (zone_read_flag & $past(zone_read_flag)) == $past(zone_read_flag))
      else $error("read flag dropped");
  AST_READ_EN:
    assert property (zone_read_en == (zone_read_flag | {3{security_valid_flag}}))
      else $error("read enable wrong");
  AST_ERASE_CLR:
    assert property (op.valid && op.addr == ADDR_ZERO
      |=> (zone_erase_flag & $past(zone_erase_flag)) == 3'h0)
      else $error("erase flag kept at zero address");
  AST_WIPE_Z1:
    assert property (p_wipe(0, 1'b1))
      else $error("zone 1 wipe wrong");
  AST_WIPE_Z3:
    assert property (p_wipe(2, 1'b0))
      else $error("zone 3 wipe wrong");
  AST_SEC_CHECK:
    assert property ($rose(security_valid_flag) |-> check_valid && check_bit)
      else $error("security flag without good check");
  AST_APB_WAIT:
    assert property (psel && !penable ##1 psel && penable |=> pready)
      else $error("apb answer late");

  // main scenarios reached
  cover property (zone_erase.req);
  cover property (check_valid && check_bit);
  cover property (op.valid && op.addr == ADDR_ZERO && zone_erase_flag != 3'h0);
endmodule : zone_flag_ctrl_monitor

bind zone_flag_ctrl zone_flag_ctrl_monitor u_mon (
  .clk(clk), .srst(srst), .op(op), .psel(psel), .penable(penable), .pready(pready),
  .zone_read_flag(zone_read_flag), .zone_read_en(zone_read_en),
  .zone_erase_flag(zone_erase_flag), .security_valid_flag(security_valid_flag),
  .check_valid(check_valid), .check_bit(check_bit), .zone_erase(zone_erase)
);

/* sim/card_reader_model.sv */
`timescale 1ns/10ps
module card_reader_model
  import zone_flag_pkg::*;
(
  input wire logic clk,
  output card_op_t op
);
  initial op = '0;

  // one op for a single edge, then released with scrambled fields
  task automatic send(input op_kind_t k, input bit_addr_t a, input logic m, input logic io);
    @(posedge clk);
    op <= '{valid: 1'b1, kind: k, addr: a, mem_bit: m, io_bit: io};
    @(posedge clk);
    op <= '{valid: 1'b0, kind: k, addr: ~a, mem_bit: ~m, io_bit: ~io};
  endtask : send

  // bit-serial password compare, ascending addresses
  task automatic run(input bit_addr_t lo, input bit_addr_t hi);
    for (bit_addr_t a = lo; a <= hi; a++)
      send(OP_COMPARE, a, a[0], a[0]);
  endtask : run
endmodule : card_reader_model

/* sim/zone_flag_ctrl_test.sv */
`timescale 1ns/10ps
module zone_flag_ctrl_test
  import zone_flag_pkg::*;
;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hf;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err, check_valid, check_bit, sec, read_allowed;
  logic [2:0] rflag, ren, eflag;
  card_op_t op;
  zone_erase_t zer;
  int failures = 0;
  int tests_run = 0;

  // clock
  always #20 clk = ~clk;

  card_reader_model reader (.clk(clk), .op(op));

  zone_flag_ctrl DUT (
    .clk(clk), .srst(srst), .op(op), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .zone_read_flag(rflag), .zone_read_en(ren), .zone_erase_flag(eflag),
    .security_valid_flag(sec), .read_allowed(read_allowed), .check_valid(check_valid),
    .check_bit(check_bit), .zone_erase(zer)
  );

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      failures++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task finish_test;
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : finish_test

  // apb transfer, waits for pready under a bound
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (i = 0; i < 16 && pready !== 1'b1; i++)
      @(posedge clk);
    if (i == 16)
    begin
      failures++;
      finish_test;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // card op, then settle to mid-cycle
  task act(input op_kind_t k, input bit_addr_t a, input logic m);
    reader.send(k, a, m, m);
    @(negedge clk);
  endtask : act

  task pw(input int z);
    reader.run(PW_LO[z], PW_HI[z]);
    repeat (3) @(posedge clk);
    @(negedge clk);
  endtask : pw

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task test_reset;
    apb(1'b0, CTRL_OFS, 32'h0);
    chk("ctrl", rd, 32'h1);
    apb(1'b0, STATUS_OFS, 32'h0);
    chk("status", rd, 32'h0);
    apb(1'b0, 12'h00c, 32'h0);
    chk("unmapped", {rd[30:0], err}, 32'h1);
    $display("test_reset done");
  endtask : test_reset

  task test_read;
    act(OP_STEP, 11'h200, 1'b0);
    chk("ra_z2", read_allowed, 32'h0);
    act(OP_STEP, RD_BIT[1], 1'b0);
    chk("rflag", rflag, 32'h0);
    act(OP_STEP, RD_BIT[1], 1'b1);
    chk("rflag", rflag, 32'h2);
    act(OP_STEP, RD_BIT[0], 1'b1);
    chk("rflag", rflag, 32'h3);
    act(OP_STEP, RD_BIT[2], 1'b1);
    chk("rflag", rflag, 32'h7);
    act(OP_STEP, RD_BIT[0], 1'b0);
    chk("rflag", rflag, 32'h7);
    act(OP_STEP, 11'h200, 1'b0);
    chk("ra_z2", read_allowed, 32'h1);
    chk("ren", ren, 32'h7);
    $display("test_read done");
  endtask : test_read

  task test_zone13;
    pw(1);
    chk("eflag", eflag, 32'h1);
    act(OP_ERASE, ZONE_TRIG[0], 1'b1);
    chk("wipe1", zer, {1'b1, ZONE_LO[0], ZONE_HI[0], 1'b1});
    act(OP_STEP, ADDR_ZERO, 1'b0);
    chk("eflag", eflag, 32'h0);
    pw(3);
    chk("eflag", eflag, 32'h4);
    act(OP_ERASE, ZONE_TRIG[2], 1'b1);
    chk("wipe3", zer, {1'b1, ZONE_LO[2], ZONE_HI[2], 1'b0});
    act(OP_STEP, ADDR_ZERO, 1'b0);
    $display("test_zone13 done");
  endtask : test_zone13

  task test_zone2;
    apb(1'b1, CTRL_OFS, 32'h0);
    apb(1'b0, CTRL_OFS, 32'h0);
    chk("ctrl", rd, 32'h0);
    pw(2);
    chk("eflag", eflag, 32'h2);
    act(OP_ERASE, ZONE_TRIG[1], 1'b1);
    chk("wipe2", zer, {1'b1, ZONE_LO[1], ZONE_HI[1], 1'b1});
    act(OP_STEP, ADDR_ZERO, 1'b0);
    apb(1'b1, CTRL_OFS, 32'h1);
    pw(2);
    chk("eflag", eflag, 32'h2);
    act(OP_WRITE, 11'h310, 1'b1);
    act(OP_ERASE, 11'h310, 1'b1);
    chk("wipe2c", zer, {1'b1, ZONE_LO[1], ZONE_HI[1], 1'b0});
    apb(1'b0, ECOUNT_OFS, 32'h0);
    chk("ecount", rd, 32'h1);
    $display("test_zone2 done");
  endtask : test_zone2

  task test_secure;
    pw(0);
    chk("sec", sec, 32'h0);
    act(OP_WRITE, 11'h061, 1'b0);
    chk("secbad", {sec, check_valid, check_bit}, 32'h2);
    pw(0);
    act(OP_WRITE, 11'h061, 1'b1);
    act(OP_ERASE, 11'h061, 1'b1);
    chk("secchk", {sec, check_valid, check_bit}, 32'h7);
    chk("ren", ren, 32'h7);
    apb(1'b0, STATUS_OFS, 32'h0);
    chk("status", rd, 32'h57);
    $display("test_secure done");
  endtask : test_secure

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    test_reset;
    test_read;
    test_zone13;
    test_zone2;
    test_secure;
    finish_test;
  end
endmodule : zone_flag_ctrl_test
